// ### bench/opp_pci_target.sv
// pci target model that answers the bridge's dword requests, fast and slow by turns
`timescale 1ns/1ps
`default_nettype none

module opp_pci_target
(
  input wire logic pclk,
  input wire logic presetn,
  input wire opp_pkg::opp_pci_req_type pci_req,
  output opp_pkg::opp_pci_rsp_type pci_rsp
);
  logic [2:0] wait_q;
  logic slow_q;

  // read data wanders outside done, so the bridge cannot lean on stale values
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_q <= 3'h0;
      slow_q <= 1'b0;
      pci_rsp <= '0;
    end
    else
    begin
      pci_rsp.done <= 1'b0;
      pci_rsp.rdata <= pci_rsp.rdata + 32'h3c3c_1235;
      if (pci_req.valid && !pci_rsp.done)
      begin
        wait_q <= wait_q + 3'h1;
        if (wait_q == {slow_q, 2'h0})
        begin
          pci_rsp <= {1'b1, ~pci_req.addr};
          wait_q <= 3'h0;
          slow_q <= ~slow_q;
        end
      end
    end
  end
endmodule // opp_pci_target

`default_nettype wire

// ### bench/test_opp_bridge.sv
// self-checking bench for the outbound bridge
`timescale 1ns/1ps
`default_nettype none

module test_opp_bridge;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  opp_pkg::opp_req_type proc_req = '0;
  opp_pkg::opp_rsp_type proc_rsp;
  opp_pkg::opp_pci_req_type pci_req;
  opp_pkg::opp_pci_rsp_type pci_rsp;
  opp_pkg::opp_pci_req_type pq[$];
  int fail_count = 0;
  int comparisons = 0;
  logic [31:0] r;
  logic e;
  logic [1:0] st;
  logic [63:0] rd = '0;
  logic [43:0] cfg[6] = '{{12'h000, 32'h1000_10ff}, {12'h004, 32'h2000_00c0}, {12'h008, 32'h2000_2000},
    {12'h00c, 32'h0100_008d}, {12'h010, 32'h3000_3000}, {12'h014, 32'h2000_0040}};
  logic [31:0] miss_a[3] = '{32'h3000_0000, 32'h1100_0000, 32'h0fff_fffc};

  always #20 pclk = ~pclk;

  opp_bridge dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .proc_req(proc_req), .proc_rsp(proc_rsp), .pci_req(pci_req), .pci_rsp(pci_rsp));
  opp_pci_target pci_u (.pclk(pclk), .presetn(presetn), .pci_req(pci_req), .pci_rsp(pci_rsp));

  // log each dword as the pci side finishes it
  always @(posedge pclk)
    if (pci_req.valid === 1'b1 && pci_rsp.done === 1'b1) pq.push_back(pci_req);

  ////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [63:0] x, input logic [63:0] g);
    comparisons++;
    if (g !== x)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask

  // a wait that runs out counts as a mismatch and ends the run
  task automatic hang(input int n);
    if (n >= 200)
    begin
      fail_count++;
      wrap_up();
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready is read as the edge samples it, so data is taken and the request released at that edge
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 200);
    hang(n);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one processor request held until its ack; ta beats leave their data in rd
  task automatic proc(input logic w, input logic b, input logic [31:0] a, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    proc_req <= {1'b1, w, b, a, s, 4'h3, {4{64'h1122_3344_5566_7788}}};
    do
    begin
      @(posedge pclk);
      n++;
      if (proc_rsp.ta === 1'b1)
        rd = proc_rsp.rdata;
    end
    while (proc_rsp.ack !== 1'b1 && n < 200);
    hang(n);
    st = {proc_rsp.artry, proc_rsp.miss};
    proc_req.valid <= 1'b0;
  endtask

  task automatic retry(input logic w, input logic b, input logic [31:0] a, input logic [3:0] s);
    int n;
    n = 0;
    do
    begin
      proc(w, b, a, s);
      n++;
    end
    while (st !== 2'b00 && n < 200);
    hang(n);
  endtask

  // quiet spell after the count is met catches extra dwords
  task automatic drain(input int k);
    int n;
    n = 0;
    while (pq.size() < k && n < 200)
    begin
      @(negedge pclk);
      n++;
    end
    hang(n);
    repeat (12) @(negedge pclk);
    chk("dword count", k, pq.size());
  endtask

  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h004, 32'h0);
    chk("attr reset", opp_pkg::WIN_RST, r);
    apb(1'b0, 12'h020, 32'h0);
    chk("threshold reset", opp_pkg::RTHR_RST, r);
    apb(1'b0, 12'h030, 32'h0);
    chk("unmapped err", 1'b1, e);
    foreach (cfg[i]) apb(1'b1, cfg[i][43:32], cfg[i][31:0]);
    foreach (cfg[i])
    begin
      apb(1'b0, cfg[i][43:32], 32'h0);
      chk("window reg", cfg[i][31:0], r);
    end
    foreach (miss_a[i])
    begin
      proc(1'b0, 1'b0, miss_a[i], 4'h4);
      chk("miss", 2'b01, st);
    end
    pq.delete();
    proc(1'b1, 1'b0, 32'h10ff_fffc, 4'h4);
    chk("posted", 2'b00, st);
    drain(1);
    chk("pci addr", 32'h30ff_fffc, pq[0].addr);
    chk("pci be", 4'hf, pq[0].be);
    chk("pci data", 32'h1122_3344, pq[0].wdata);
    chk("pci write", 1'b1, pq[0].write);
    pq.delete();
    proc(1'b1, 1'b0, 32'h1000_0000, 4'h8);
    drain(2);
    chk("low dword", 32'h5566_7788, pq[0].wdata);
    chk("high addr", 32'h3000_0004, pq[1].addr);
    pq.delete();
    proc(1'b0, 1'b0, 32'h1000_0010, 4'h4);
    chk("read first", 2'b10, st);
    proc(1'b1, 1'b0, 32'h1000_0020, 4'h4);
    chk("post beside read", 2'b00, st);
    retry(1'b0, 1'b0, 32'h1000_0010, 4'h4);
    chk("read data", 32'hcfff_ffef, rd[31:0]);
    drain(2);
    chk("read dir", 1'b0, pq[0].write);
    chk("read addr", 32'h3000_0010, pq[0].addr);
    pq.delete();
    proc(1'b1, 1'b0, 32'h2000_0008, 4'h4);
    chk("write first", 2'b10, st);
    retry(1'b1, 1'b0, 32'h2000_0008, 4'h4);
    drain(1);
    chk("io addr", 32'h2100_0008, pq[0].addr);
    chk("io space", 1'b1, pq[0].io);
    chk("xfer", 3'h5, pq[0].xfer);
    pq.delete();
    proc(1'b1, 1'b1, 32'h2000_0020, 4'h8);
    chk("burst posted", 2'b00, st);
    drain(8);
    chk("burst end", 32'h2100_003c, pq[7].addr);
    proc(1'b0, 1'b1, 32'h1000_0040, 4'h8);
    chk("burst read first", 2'b10, st);
    retry(1'b0, 1'b1, 32'h1000_0040, 4'h8);
    chk("burst read", 64'hcfff_ffa3_cfff_ffa7, rd);
    apb(1'b0, 12'h024, 32'h0);
    chk("status idle", 32'h2000_0000, r);
    wrap_up();
  end
endmodule // test_opp_bridge

`default_nettype wire

// ### rtl/opp_bridge.sv
// outbound processor-to-pci path: window decode, slave with delayed transactions, fifos, pci master
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none

//Operation
//- four programmable windows, memory or io
//- forward only hits in enabled window range
//- compare upper 16 bits, 64 KB resolution
//- per-window attributes steer decode and posting
//- pci upper address is upper plus offset
//- posted writes, compelled writes and reads
//- first compelled attempt always gets retry
//- accept compelled only when fifos favorable
//- accept posts entry, data, saves identity
//- retry repeats until delayed transaction completes
//- pci master drains write or fills read
//- matching retry after completion finishes cycle
//- burst writes always posted
//- posts beside pending read only, with room
//- command fifo 50 by 8, full retries
//- independent 256 byte read, write fifos
//- read fill stalls at limit until threshold
//- full write fifo retries processor cycles
//- no byte merging, one transfer per dword
//- queued commands are never snooped
//- single beats split into 32-bit transfers
module opp_bridge
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire opp_pkg::opp_req_type proc_req,
  output opp_pkg::opp_rsp_type proc_rsp,
  output opp_pkg::opp_pci_req_type pci_req,
  input wire opp_pkg::opp_pci_rsp_type pci_rsp
);

  typedef struct packed {
    opp_pkg::opp_range_type [opp_pkg::NWIN-1:0] rng;
    opp_pkg::opp_attr_type [opp_pkg::NWIN-1:0] attr;
    logic [5:0] rthr;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    opp_pkg::opp_sl_type sl;
    opp_pkg::opp_rsp_type rsp;
    logic [2:0] beat;
    opp_pkg::opp_dt_type dt;
    opp_pkg::opp_cmd_type dtc;
    opp_pkg::opp_pm_type pm;
    opp_pkg::opp_cmd_type cmd;
    logic [2:0] dw;
    logic [3:0] left;
    logic [63:0] hold;
    logic rstall;
    opp_pkg::opp_pci_req_type preq;
  } opp_st_type;

  opp_st_type st_q;
  opp_st_type st_d;

  logic [opp_pkg::NWIN-1:0] hit;
  logic any_hit;
  logic [1:0] win_sel;
  opp_pkg::opp_attr_type attr_sel;
  opp_pkg::opp_cmd_type req_cmd;
  logic take;
  logic posted;
  logic match;
  logic [5:0] need;
  logic [5:0] wfree;
  logic [3:0] pop_end;
  logic [3:0] cur_end;
  logic [3:0] cur_be;
  opp_pkg::opp_stat_type stat;

  logic cmd_push;
  logic cmd_pop;
  opp_pkg::opp_cmd_type cmd_din;
  opp_pkg::opp_cmd_type cmd_dout;
  logic [3:0] cmd_count;
  logic cmd_full;
  logic cmd_empty;
  logic wf_push;
  logic wf_pop;
  logic [63:0] wf_din;
  logic [63:0] wf_dout;
  logic [5:0] wf_count;
  logic rf_push;
  logic rf_pop;
  logic [63:0] rf_din;
  logic [63:0] rf_dout;
  logic [5:0] rf_count;
  logic rf_full;

  ////////////////////////////////////////////////////////////////////////////////
  // fifos: command path plus independent write and read data paths
  opp_fifo #(.W(opp_pkg::CMD_W), .D(opp_pkg::CMD_D)) u_cmd_fifo (
    .pclk(pclk), .presetn(presetn), .push(cmd_push), .din(cmd_din), .pop(cmd_pop),
    .dout(cmd_dout), .count(cmd_count), .full(cmd_full), .empty(cmd_empty));

  opp_fifo #(.W(opp_pkg::DAT_W), .D(opp_pkg::DAT_D)) u_wr_fifo (
    .pclk(pclk), .presetn(presetn), .push(wf_push), .din(wf_din), .pop(wf_pop),
    .dout(wf_dout), .count(wf_count), .full(), .empty());

  opp_fifo #(.W(opp_pkg::DAT_W), .D(opp_pkg::DAT_D)) u_rd_fifo (
    .pclk(pclk), .presetn(presetn), .push(rf_push), .din(rf_din), .pop(rf_pop),
    .dout(rf_dout), .count(rf_count), .full(rf_full), .empty());

  ////////////////////////////////////////////////////////////////////////////////
  // window decode: upper 16 address bits against each enabled range
  genvar gi;
  generate
    for (gi = 0; gi < opp_pkg::NWIN; gi++)
    begin : g_win
      assign hit[gi] = st_q.attr[gi].en && (proc_req.addr[31:16] >= st_q.rng[gi].base)
        && (proc_req.addr[31:16] <= st_q.rng[gi].limit);
    end
  endgenerate

  // overlapping windows are undefined; the lowest index simply wins
  always_comb
  begin
    win_sel = 2'h0;
    for (int i = opp_pkg::NWIN - 1; i >= 0; i--)
      if (hit[i])
        win_sel = 2'(i);
  end

  assign any_hit = |hit;
  assign attr_sel = st_q.attr[win_sel];
  // burst writes cannot be retried after the first beat, so they always post
  assign posted = proc_req.write && (proc_req.burst || attr_sel.wpe);
  assign take = proc_req.valid && (st_q.sl == opp_pkg::SL_IDLE) && !st_q.rsp.ack;
  assign need = proc_req.burst ? opp_pkg::BURST_BEATS : opp_pkg::SINGLE_BEATS;
  assign wfree = opp_pkg::DAT_DEPTH - wf_count;

  // command as it would be queued: translated address plus identity
  always_comb
  begin
    req_cmd = '0;
    req_cmd.addr = {proc_req.addr[31:16] + attr_sel.offset, proc_req.addr[15:0]};
    req_cmd.write = proc_req.write;
    req_cmd.compelled = !posted;
    req_cmd.burst = proc_req.burst;
    req_cmd.io = attr_sel.io;
    req_cmd.size = proc_req.size;
    req_cmd.mid = proc_req.mid;
    req_cmd.win = win_sel;
    req_cmd.xfer = attr_sel.xfer;
  end

  // a retried cycle closes the delayed transaction only if everything matches
  assign match = (req_cmd == st_q.dtc);

  ////////////////////////////////////////////////////////////////////////////////
  // single-beat split: byte enables of the current dword within the 8-byte beat
  assign pop_end = {1'b0, cmd_dout.addr[2:0]} + cmd_dout.size - 4'h1;
  assign cur_end = {1'b0, st_q.cmd.addr[2:0]} + st_q.cmd.size - 4'h1;

  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++)
    begin : g_be
      assign cur_be[gb] = st_q.cmd.burst || (({st_q.dw[0], 2'(gb)} >= st_q.cmd.addr[2:0])
        && ({st_q.dw[0], 2'(gb)} <= cur_end[2:0]));
    end
  endgenerate

  always_comb
  begin
    stat = '0;
    stat.dt = st_q.dt;
    stat.cmd_cnt = cmd_count;
    stat.wr_cnt = wf_count;
    stat.rd_cnt = rf_count;
    stat.rd_stall = st_q.rstall;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state: apb slave, processor-side slave, pci master
  always_comb
  begin
    st_d = st_q;
    st_d.rsp = '0;
    st_d.pready = 1'b0;
    st_d.pslverr = 1'b0;
    cmd_push = 1'b0;
    cmd_pop = 1'b0;
    cmd_din = req_cmd;
    wf_push = 1'b0;
    wf_pop = 1'b0;
    wf_din = proc_req.wdata[63:0];
    rf_push = 1'b0;
    rf_pop = 1'b0;
    rf_din = st_q.hold;

    // apb: read data is latched in setup so the access phase ends after one cycle
    if (psel && !penable)
    begin
      st_d.pready = 1'b1;
      if ((paddr < opp_pkg::REG_RTHR) && (paddr[1:0] == 2'h0))
      begin
        if (paddr[opp_pkg::WIN_ATTR_BIT])
          st_d.prdata = st_q.attr[paddr[opp_pkg::WIN_IDX_LSB +: 2]];
        else
          st_d.prdata = st_q.rng[paddr[opp_pkg::WIN_IDX_LSB +: 2]];
      end
      else if (paddr == opp_pkg::REG_RTHR)
        st_d.prdata = {26'h0, st_q.rthr};
      else if (paddr == opp_pkg::REG_STAT)
        st_d.prdata = stat;
      else
      begin
        st_d.prdata = '0;
        st_d.pslverr = 1'b1;
      end
    end
    if (psel && penable && st_q.pready && pwrite && !st_q.pslverr)
    begin
      if (paddr < opp_pkg::REG_RTHR)
      begin
        if (paddr[opp_pkg::WIN_ATTR_BIT])
        begin
          st_d.attr[paddr[opp_pkg::WIN_IDX_LSB +: 2]] = pwdata;
          st_d.attr[paddr[opp_pkg::WIN_IDX_LSB +: 2]].rsvd = '0;
        end
        else
          st_d.rng[paddr[opp_pkg::WIN_IDX_LSB +: 2]] = pwdata;
      end
      else if (paddr == opp_pkg::REG_RTHR)
        st_d.rthr = pwdata[5:0];
    end

    // processor-side slave; the queue is never snooped against new cycles
    case (st_q.sl)
      opp_pkg::SL_IDLE:
      begin
        if (take)
        begin
          st_d.rsp.ack = 1'b1;
          if (!any_hit)
            st_d.rsp.miss = 1'b1;
          else if (posted)
          begin
            // posts wait behind a queued compelled write and for room in both fifos
            if (cmd_full || (wfree < need) || ((st_q.dt == opp_pkg::DT_BUSY) && st_q.dtc.write))
              st_d.rsp.artry = 1'b1;
            else
            begin
              cmd_push = 1'b1;
              wf_push = 1'b1;
              if (proc_req.burst)
              begin
                st_d.rsp.ack = 1'b0;
                st_d.beat = 3'h1;
                st_d.sl = opp_pkg::SL_WPUSH;
              end
              else
                st_d.rsp.ta = 1'b1;
            end
          end
          else if (st_q.dt == opp_pkg::DT_IDLE)
          begin
            // first attempt is retried whether or not it is taken
            st_d.rsp.artry = 1'b1;
            if (!cmd_full && (!proc_req.write || (wfree != 6'h00)))
            begin
              cmd_push = 1'b1;
              wf_push = proc_req.write;
              st_d.dtc = req_cmd;
              st_d.dt = opp_pkg::DT_BUSY;
            end
          end
          else if ((st_q.dt == opp_pkg::DT_DONE) && match)
          begin
            if (st_q.dtc.write)
            begin
              st_d.rsp.ta = 1'b1;
              st_d.dt = opp_pkg::DT_IDLE;
            end
            else
            begin
              st_d.rsp.ack = 1'b0;
              st_d.beat = 3'h0;
              st_d.sl = opp_pkg::SL_RDOUT;
            end
          end
          else
            st_d.rsp.artry = 1'b1;
        end
      end
      opp_pkg::SL_WPUSH:
      begin
        wf_push = 1'b1;
        wf_din = proc_req.wdata[st_q.beat[1:0] * 64 +: 64];
        st_d.beat = st_q.beat + 3'h1;
        if (st_q.beat == opp_pkg::LAST_BURST_BEAT)
        begin
          st_d.rsp.ack = 1'b1;
          st_d.rsp.ta = 1'b1;
          st_d.sl = opp_pkg::SL_IDLE;
        end
      end
      opp_pkg::SL_RDOUT:
      begin
        rf_pop = 1'b1;
        st_d.rsp.ta = 1'b1;
        st_d.rsp.rdata = rf_dout;
        st_d.beat = st_q.beat + 3'h1;
        if (!st_q.dtc.burst || (st_q.beat == opp_pkg::LAST_BURST_BEAT))
        begin
          st_d.rsp.ack = 1'b1;
          st_d.dt = opp_pkg::DT_IDLE;
          st_d.sl = opp_pkg::SL_IDLE;
        end
      end
      default:
        st_d.sl = opp_pkg::SL_IDLE;
    endcase

    // read fill hysteresis: stop at full, resume once drained to the threshold
    if (rf_full)
      st_d.rstall = 1'b1;
    else if (rf_count <= st_q.rthr)
      st_d.rstall = 1'b0;

    // pci master: one command at a time, one dword per pci transfer
    case (st_q.pm)
      opp_pkg::PM_IDLE:
      begin
        if (!cmd_empty)
        begin
          cmd_pop = 1'b1;
          st_d.cmd = cmd_dout;
          st_d.pm = opp_pkg::PM_RUN;
          if (cmd_dout.burst)
          begin
            st_d.dw = 3'h0;
            st_d.left = opp_pkg::BURST_DWORDS;
          end
          else
          begin
            // each single beat goes out on its own, one or two dwords
            st_d.dw = cmd_dout.addr[4:2];
            st_d.left = {2'h0, pop_end[3:2]} - {3'h0, cmd_dout.addr[2]} + 4'h1;
          end
        end
      end
      opp_pkg::PM_RUN:
      begin
        if (st_q.cmd.write || !(st_q.rstall || rf_full))
        begin
          st_d.preq.valid = 1'b1;
          st_d.preq.write = st_q.cmd.write;
          st_d.preq.io = st_q.cmd.io;
          st_d.preq.xfer = st_q.cmd.xfer;
          st_d.preq.addr = {st_q.cmd.addr[31:5], st_q.dw, 2'h0};
          st_d.preq.be = cur_be;
          st_d.preq.wdata = st_q.dw[0] ? wf_dout[63:32] : wf_dout[31:0];
          st_d.pm = opp_pkg::PM_WAIT;
        end
      end
      opp_pkg::PM_WAIT:
      begin
        if (pci_rsp.done)
        begin
          st_d.preq.valid = 1'b0;
          if (st_q.dw[0])
            st_d.hold[63:32] = pci_rsp.rdata;
          else
            st_d.hold[31:0] = pci_rsp.rdata;
          if (st_q.dw[0] || (st_q.left == 4'h1))
          begin
            wf_pop = st_q.cmd.write;
            rf_push = !st_q.cmd.write;
            rf_din = st_d.hold;
          end
          if (st_q.left == 4'h1)
          begin
            st_d.pm = opp_pkg::PM_IDLE;
            if (st_q.cmd.compelled)
              st_d.dt = opp_pkg::DT_DONE;
          end
          else
          begin
            st_d.dw = st_q.dw + 3'h1;
            st_d.left = st_q.left - 4'h1;
            st_d.pm = opp_pkg::PM_RUN;
          end
        end
      end
      default:
        st_d.pm = opp_pkg::PM_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register; windows come up disabled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= '0;
      st_q.rng <= {opp_pkg::NWIN{opp_pkg::WIN_RST}};
      st_q.attr <= {opp_pkg::NWIN{opp_pkg::WIN_RST}};
      st_q.rthr <= opp_pkg::RTHR_RST;
      st_q.sl <= opp_pkg::SL_IDLE;
      st_q.dt <= opp_pkg::DT_IDLE;
      st_q.pm <= opp_pkg::PM_IDLE;
    end
    else
      st_q <= st_d;
  end

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign proc_rsp = st_q.rsp;
  assign pci_req = st_q.preq;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_new_compelled;
    take && any_hit && !posted && (st_q.dt == opp_pkg::DT_IDLE);
  endsequence

  sequence s_close_single_read;
    take && any_hit && !posted && (st_q.dt == opp_pkg::DT_DONE) && match && !st_q.dtc.write && !st_q.dtc.burst;
  endsequence

  AST_FIRST_RETRY: assert property (s_new_compelled |=> proc_rsp.ack && proc_rsp.artry && !proc_rsp.ta)
    else $error("first compelled attempt not retried");
  AST_ONE_DELAYED: assert property (cmd_push && cmd_din.compelled |-> st_q.dt == opp_pkg::DT_IDLE)
    else $error("second delayed transaction queued");
  AST_MISS: assert property (take && !any_hit |=> proc_rsp.ack && proc_rsp.miss && !proc_rsp.artry)
    else $error("miss not reported");
  AST_BUSY_RETRY: assert property (take && any_hit && !posted && st_q.dt == opp_pkg::DT_BUSY |=> proc_rsp.artry)
    else $error("retry during service missing");
  AST_BURST_POSTED: assert property (cmd_push && cmd_din.burst && cmd_din.write |-> !cmd_din.compelled)
    else $error("burst write queued as compelled");
  // a matching close of a finished delayed write may still answer with ta while the queue is full
  AST_CMD_FULL: assert property (take && cmd_full && st_q.dt != opp_pkg::DT_DONE |-> !cmd_push ##1 !proc_rsp.ta)
    else $error("push into full command fifo");
  AST_RD_STALL: assert property (st_q.rstall && !st_q.cmd.write && st_q.pm == opp_pkg::PM_RUN |=> !pci_req.valid)
    else $error("read issued while stalled");
  AST_XLATE: assert property (cmd_push |-> (cmd_din.addr[31:16] == proc_req.addr[31:16] + attr_sel.offset)
    && (cmd_din.addr[15:0] == proc_req.addr[15:0]))
    else $error("address translation wrong");
  // the take only moves the slave to read-out; the pop shows one cycle later
  AST_CLOSE_READ: assert property (s_close_single_read |=> !proc_rsp.ta && !proc_rsp.ack ##1 proc_rsp.ack && proc_rsp.ta
    && st_q.dt == opp_pkg::DT_IDLE)
    else $error("matching read retry not completed");
  AST_SPLIT: assert property (st_q.pm == opp_pkg::PM_IDLE && !cmd_empty && !cmd_dout.burst
    |=> st_q.left != 4'h0 && st_q.left <= 4'h2)
    else $error("single beat not split into one or two dwords");

endmodule // opp_bridge

`default_nettype wire

// ### rtl/opp_fifo.sv
// flip-flop fifo used for the command, write data and read data paths
`timescale 1ns/1ps
`default_nettype none

module opp_fifo
#(
  parameter int W = 64,
  parameter int D = 32,
  parameter int AW = $clog2(D)
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic push,
  input wire logic [W-1:0] din,
  input wire logic pop,
  output logic [W-1:0] dout,
  output logic [AW:0] count,
  output logic full,
  output logic empty
);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } opp_fifo_st_type;

  opp_fifo_st_type st_q;
  opp_fifo_st_type st_d;
  logic do_push;
  logic do_pop;

  ////////////////////////////////////////////////////////////////////////////////
  // a push into a full fifo or a pop from an empty one is dropped; callers check first
  assign do_push = push && !full;
  assign do_pop = pop && !empty;

  always_comb
  begin
    st_d = st_q;
    if (do_push)
    begin
      st_d.mem[st_q.wp] = din;
      st_d.wp = st_q.wp + 1'b1;
    end
    if (do_pop)
      st_d.rp = st_q.rp + 1'b1;
    if (do_push && !do_pop)
      st_d.cnt = st_q.cnt + 1'b1;
    else if (do_pop && !do_push)
      st_d.cnt = st_q.cnt - 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  // head is shown ahead, valid whenever the fifo is not empty
  assign dout = st_q.mem[st_q.rp];
  assign count = st_q.cnt;
  assign full = (st_q.cnt == (AW+1)'(D));
  assign empty = (st_q.cnt == '0);

endmodule // opp_fifo

`default_nettype wire

// ### rtl/opp_pkg.sv
// shared constants, register layouts and carrier types for the outbound processor-to-pci path
package opp_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int NWIN = 4;
  localparam int CMD_W = 50;
  localparam int CMD_D = 8;
  localparam int DAT_W = 64;
  localparam int DAT_D = 32;
  localparam logic [5:0] DAT_DEPTH = 6'h20;
  localparam logic [5:0] BURST_BEATS = 6'h04;
  localparam logic [5:0] SINGLE_BEATS = 6'h01;
  localparam logic [2:0] LAST_BURST_BEAT = 3'h3;
  localparam logic [3:0] BURST_DWORDS = 4'h8;

  ////////////////////////////////////////////////////////////////////////////////
  // apb register map (window n: range at 8*n, attributes at 8*n+4)
  localparam logic [11:0] REG_WIN_BASE = 12'h000;
  localparam logic [11:0] REG_RTHR = 12'h020;
  localparam logic [11:0] REG_STAT = 12'h024;
  localparam int WIN_IDX_LSB = 3;
  localparam int WIN_ATTR_BIT = 2;
  localparam logic [31:0] WIN_RST = 32'h0000_0000;
  localparam logic [5:0] RTHR_RST = 6'h10;

  ////////////////////////////////////////////////////////////////////////////////
  // state encodings
  typedef enum logic [2:0] {DT_IDLE = 3'b001, DT_BUSY = 3'b010, DT_DONE = 3'b100} opp_dt_type;
  typedef enum logic [2:0] {SL_IDLE = 3'b001, SL_WPUSH = 3'b010, SL_RDOUT = 3'b100} opp_sl_type;
  typedef enum logic [2:0] {PM_IDLE = 3'b001, PM_RUN = 3'b010, PM_WAIT = 3'b100} opp_pm_type;

  ////////////////////////////////////////////////////////////////////////////////
  // register layouts
  typedef struct packed {
    logic [15:0] base;   // first 64 KB block of the window
    logic [15:0] limit;  // last 64 KB block, inclusive
  } opp_range_type;

  typedef struct packed {
    logic [15:0] offset;
    logic [7:0] rsvd;
    logic en;
    logic wpe;
    logic sge;
    logic rae;
    logic io;
    logic [2:0] xfer;
  } opp_attr_type;

  typedef struct packed {
    opp_dt_type dt;
    logic rsvd0;
    logic [3:0] cmd_cnt;
    logic [1:0] rsvd1;
    logic [5:0] wr_cnt;
    logic [1:0] rsvd2;
    logic [5:0] rd_cnt;
    logic [6:0] rsvd3;
    logic rd_stall;
  } opp_stat_type;

  ////////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic valid;
    logic write;
    logic burst;
    logic [31:0] addr;
    logic [3:0] size;
    logic [3:0] mid;
    logic [255:0] wdata;
  } opp_req_type;

  typedef struct packed {
    logic ack;
    logic artry;
    logic ta;
    logic miss;
    logic [63:0] rdata;
  } opp_rsp_type;

  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic compelled;
    logic burst;
    logic io;
    logic [3:0] size;
    logic [3:0] mid;
    logic [1:0] win;
    logic [2:0] xfer;
    logic rsvd;
  } opp_cmd_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic io;
    logic [2:0] xfer;
    logic [31:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } opp_pci_req_type;

  typedef struct packed {
    logic done;
    logic [31:0] rdata;
  } opp_pci_rsp_type;

endpackage
